/* verilog/decoder_pkg.sv */
// Constants, types and carriers shared by the instruction decoder.
package decoder_pkg;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] BANK_OFS = 12'h004;
    localparam logic [11:0] PROD_LO_OFS = 12'h008;
    localparam logic [11:0] PROD_HI_OFS = 12'h00c;
    localparam logic [11:0] STAT_OFS = 12'h010;
    localparam logic [3:0] ACCESS_BANK = 4'h0;
    localparam logic [11:0] PORT_LO = 12'hf00;
    localparam logic [11:0] PORT_HI = 12'hf04;
    localparam logic [11:0] TIMER_ADDR = 12'hf10;
    localparam logic [3:0] SECOND_PREFIX = 4'hf;
    // Flag masks are ordered carry, digit carry, zero, overflow, negative.
    localparam logic [4:0] FL_ALL = 5'h1f;
    localparam logic [4:0] FL_ZN = 5'h05;
    localparam logic [4:0] FL_CZN = 5'h15;
    localparam logic [4:0] FL_Z = 5'h04;
    localparam logic [4:0] FL_NONE = 5'h00;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    typedef enum logic [5:0] {
        OP_NOP, OP_ADDC, OP_ADD, OP_INC, OP_DEC, OP_OR, OP_AND, OP_XOR, OP_COMPL,
        OP_CPLT, OP_CPEQ, OP_CPGT, OP_DECSZ, OP_INCSZ, OP_TSTSZ, OP_INCSNZ, OP_DECSNZ,
        OP_RLC, OP_RRC, OP_RL, OP_RR, OP_SUBF, OP_SUBFB, OP_SUBAB, OP_MUL, OP_MOV,
        OP_CLR, OP_SET, OP_NEG, OP_STORE, OP_SWAP, OP_FMOVE, OP_BITOP, OP_LIT,
        OP_RELBR, OP_BCOND, OP_JUMP, OP_CALL, OP_OTHER
    } op_e;

    typedef enum logic {PH_FIRST, PH_SECOND} phase_e;

    typedef struct packed {
        logic valid;
        op_e op;
        logic dest_file;
        logic [11:0] addr;
        logic [11:0] fdst;
        logic [2:0] bit_sel;
        logic [7:0] literal;
        logic [10:0] offset;
        logic [19:0] target;
        logic fast;
        logic [4:0] flags;
        logic [1:0] cycles;
        logic skip_op;
        logic pin_src;
        logic pre_clr;
    } dec_s;

    typedef struct packed {
        logic res_zero;
        logic cmp_lt;
        logic cmp_eq;
        logic cmp_gt;
        logic [7:0] acc;
        logic [7:0] file_data;
    } dp_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;
endpackage : decoder_pkg

/* verilog/byte_bit_instruction_decoder.sv */
// Instruction word decoder with two-word, skip and flush sequencing.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module byte_bit_instruction_decoder (
    // Clock and reset.
    input wire logic I_MCLK,
    input wire logic I_RST,
    // Instruction words from the fetch path.
    input wire logic [15:0] I_INSTR,
    input wire logic I_INSTR_VLD,
    // Results from the datapath for the decoded instruction.
    input wire decoder_pkg::dp_s I_DP,
    // Register bus.
    input wire decoder_pkg::apb_req_s I_APB,
    output decoder_pkg::apb_rsp_s O_APB,
    // Decoded instruction, sequencing and the multiply product bytes.
    output decoder_pkg::dec_s O_DEC,
    output logic O_SKIP,
    output logic [1:0] O_SKIP_CYC,
    output logic [7:0] O_PROD_HI,
    output logic [7:0] O_PROD_LO
);

    typedef struct packed {
        decoder_pkg::phase_e phase;
        decoder_pkg::op_e pend;
        logic [11:0] hold12;
        logic [7:0] lo;
        logic fast;
        logic [1:0] squash;
        logic skip_arm;
        decoder_pkg::dec_s dec;
        logic skip;
        logic [1:0] skip_cyc;
        logic pre_asg;
        logic [3:0] bank;
        logic [15:0] prod;
        logic [31:0] prdata;
        logic slverr;
    } st_s;

    st_s st_r;
    st_s st_nxt;
    logic skip_cond;
    logic skip_now;
    logic fresh;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic two_word(input logic [15:0] w);
        two_word = (w[15:12] == 4'hc) || (w[15:9] == 7'h76) || (w[15:9] == 7'h77);
    endfunction : two_word

    function automatic decoder_pkg::dec_s decode(input logic [15:0] w, input logic [3:0] bank,
                                                 input logic pa);
        decoder_pkg::dec_s d;
        logic byte_op;
        logic bit_op;
        d = '0;
        byte_op = 1'b1;
        bit_op = 1'b0;
        d.valid = 1'b1;
        d.cycles = decoder_pkg::CYC_ONE;
        d.dest_file = w[9];
        d.addr = {(w[8] ? bank : decoder_pkg::ACCESS_BANK), w[7:0]};
        d.bit_sel = w[11:9];
        d.literal = w[7:0];
        d.offset = (w[15:12] == 4'hd) ? w[10:0] : {{3{w[7]}}, w[7:0]};
        d.flags = decoder_pkg::FL_NONE;
        casez (w[15:8])
            8'b0010_00??: begin d.op = decoder_pkg::OP_ADDC; d.flags = decoder_pkg::FL_ALL; end
            8'b0010_01??: begin d.op = decoder_pkg::OP_ADD; d.flags = decoder_pkg::FL_ALL; end
            8'b0010_10??: begin d.op = decoder_pkg::OP_INC; d.flags = decoder_pkg::FL_ALL; end
            8'b0000_01??: begin d.op = decoder_pkg::OP_DEC; d.flags = decoder_pkg::FL_ALL; end
            8'b0001_00??: begin d.op = decoder_pkg::OP_OR; d.flags = decoder_pkg::FL_ZN; end
            8'b0001_01??: begin d.op = decoder_pkg::OP_AND; d.flags = decoder_pkg::FL_ZN; end
            8'b0001_10??: begin d.op = decoder_pkg::OP_XOR; d.flags = decoder_pkg::FL_ZN; end
            8'b0001_11??: begin d.op = decoder_pkg::OP_COMPL; d.flags = decoder_pkg::FL_ZN; end
            8'b0110_000?: begin d.op = decoder_pkg::OP_CPLT; d.skip_op = 1'b1; end
            8'b0110_001?: begin d.op = decoder_pkg::OP_CPEQ; d.skip_op = 1'b1; end
            8'b0110_010?: begin d.op = decoder_pkg::OP_CPGT; d.skip_op = 1'b1; end
            8'b0010_11??: begin d.op = decoder_pkg::OP_DECSZ; d.skip_op = 1'b1; end
            8'b0011_11??: begin d.op = decoder_pkg::OP_INCSZ; d.skip_op = 1'b1; end
            8'b0110_011?: begin d.op = decoder_pkg::OP_TSTSZ; d.skip_op = 1'b1; end
            8'b0100_10??: begin d.op = decoder_pkg::OP_INCSNZ; d.skip_op = 1'b1; end
            8'b0100_11??: begin d.op = decoder_pkg::OP_DECSNZ; d.skip_op = 1'b1; end
            8'b0011_01??: begin d.op = decoder_pkg::OP_RLC; d.flags = decoder_pkg::FL_CZN; end
            8'b0011_00??: begin d.op = decoder_pkg::OP_RRC; d.flags = decoder_pkg::FL_CZN; end
            8'b0100_01??: begin d.op = decoder_pkg::OP_RL; d.flags = decoder_pkg::FL_ZN; end
            8'b0100_00??: begin d.op = decoder_pkg::OP_RR; d.flags = decoder_pkg::FL_ZN; end
            8'b0101_11??: begin d.op = decoder_pkg::OP_SUBF; d.flags = decoder_pkg::FL_ALL; end
            8'b0101_10??: begin d.op = decoder_pkg::OP_SUBFB; d.flags = decoder_pkg::FL_ALL; end
            8'b0101_01??: begin d.op = decoder_pkg::OP_SUBAB; d.flags = decoder_pkg::FL_ALL; end
            8'b0000_001?: begin d.op = decoder_pkg::OP_MUL; d.dest_file = 1'b0; end
            8'b0101_00??: begin d.op = decoder_pkg::OP_MOV; d.flags = decoder_pkg::FL_ZN; end
            8'b0011_10??: d.op = decoder_pkg::OP_SWAP;
            8'b0110_100?: begin d.op = decoder_pkg::OP_SET; d.dest_file = 1'b1; end
            8'b0110_101?: begin d.op = decoder_pkg::OP_CLR; d.dest_file = 1'b1; d.flags = decoder_pkg::FL_Z; end
            8'b0110_110?: begin d.op = decoder_pkg::OP_NEG; d.dest_file = 1'b1; d.flags = decoder_pkg::FL_ALL; end
            8'b0110_111?: begin d.op = decoder_pkg::OP_STORE; d.dest_file = 1'b1; end
            8'b1100_????: begin d.op = decoder_pkg::OP_FMOVE; d.cycles = decoder_pkg::CYC_TWO; byte_op = 1'b0; end
            8'b0111_????, 8'b10??_????: begin d.op = decoder_pkg::OP_BITOP; byte_op = 1'b0; bit_op = 1'b1; end
            8'b1101_0???: begin d.op = decoder_pkg::OP_RELBR; d.cycles = decoder_pkg::CYC_TWO; byte_op = 1'b0; end
            8'b1110_0???: begin d.op = decoder_pkg::OP_BCOND; byte_op = 1'b0; end
            8'b1110_110?: begin d.op = decoder_pkg::OP_CALL; d.cycles = decoder_pkg::CYC_TWO; byte_op = 1'b0; end
            8'b1110_1111: begin d.op = decoder_pkg::OP_JUMP; d.cycles = decoder_pkg::CYC_TWO; byte_op = 1'b0; end
            8'b0000_1???: begin d.op = decoder_pkg::OP_LIT; byte_op = 1'b0; end
            8'b1111_????: begin d.op = decoder_pkg::OP_NOP; byte_op = 1'b0; end
            default: begin d.op = decoder_pkg::OP_OTHER; byte_op = 1'b0; end
        endcase
        // Compares and the zero test only read, so they never claim the file as target.
        if (d.op == decoder_pkg::OP_CPLT || d.op == decoder_pkg::OP_CPEQ || d.op == decoder_pkg::OP_CPGT ||
            d.op == decoder_pkg::OP_TSTSZ) begin
            d.dest_file = 1'b0;
        end
        if (bit_op) begin
            d.dest_file = 1'b1;
        end else if (!byte_op) begin
            d.dest_file = 1'b0;
        end
        // A port rewritten from itself must see the pins, not the output latch.
        d.pin_src = byte_op && d.dest_file && d.addr >= decoder_pkg::PORT_LO && d.addr <= decoder_pkg::PORT_HI &&
                    d.op != decoder_pkg::OP_CLR && d.op != decoder_pkg::OP_SET && d.op != decoder_pkg::OP_STORE;
        d.pre_clr = pa && d.dest_file && d.addr == decoder_pkg::TIMER_ADDR;
        decode = d;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        case (st_r.dec.op)
            decoder_pkg::OP_CPLT: skip_cond = I_DP.cmp_lt;
            decoder_pkg::OP_CPEQ: skip_cond = I_DP.cmp_eq;
            decoder_pkg::OP_CPGT: skip_cond = I_DP.cmp_gt;
            decoder_pkg::OP_DECSZ, decoder_pkg::OP_INCSZ, decoder_pkg::OP_TSTSZ: skip_cond = I_DP.res_zero;
            decoder_pkg::OP_INCSNZ, decoder_pkg::OP_DECSNZ: skip_cond = !I_DP.res_zero;
            default: skip_cond = 1'b0;
        endcase
    end

    assign skip_now = st_r.dec.valid && st_r.dec.skip_op && skip_cond;
    assign fresh = I_INSTR_VLD && !skip_now && !st_r.skip_arm && st_r.squash == 2'h0 && st_r.phase == decoder_pkg::PH_FIRST;

    always_comb begin
        st_nxt = st_r;
        st_nxt.dec = '0;
        st_nxt.skip = 1'b0;
        st_nxt.skip_cyc = 2'h0;
        if (skip_now && !I_INSTR_VLD) begin
            st_nxt.skip_arm = 1'b1;
        end
        if (I_INSTR_VLD) begin
            if (skip_now || st_r.skip_arm) begin
                // The skipped word becomes a no-operation; a two-word one also drops its operand word.
                st_nxt.skip_arm = 1'b0;
                st_nxt.skip = 1'b1;
                st_nxt.skip_cyc = two_word(I_INSTR) ? decoder_pkg::CYC_THREE : decoder_pkg::CYC_TWO;
                st_nxt.squash = two_word(I_INSTR) ? 2'h1 : 2'h0;
                st_nxt.dec.valid = 1'b1;
                st_nxt.dec.cycles = decoder_pkg::CYC_ONE;
            end else if (st_r.squash != 2'h0) begin
                st_nxt.squash = st_r.squash - 2'h1;
                st_nxt.dec.valid = 1'b1;
                st_nxt.dec.cycles = decoder_pkg::CYC_ONE;
            end else if (st_r.phase == decoder_pkg::PH_SECOND) begin
                st_nxt.phase = decoder_pkg::PH_FIRST;
                st_nxt.dec.valid = 1'b1;
                st_nxt.dec.cycles = decoder_pkg::CYC_ONE;
                // A malformed operand word is dropped as a no-operation.
                if (I_INSTR[15:12] == decoder_pkg::SECOND_PREFIX) begin
                    st_nxt.dec.op = st_r.pend;
                    st_nxt.dec.cycles = decoder_pkg::CYC_TWO;
                    st_nxt.dec.addr = st_r.hold12;
                    st_nxt.dec.fdst = I_INSTR[11:0];
                    if (st_r.pend == decoder_pkg::OP_JUMP || st_r.pend == decoder_pkg::OP_CALL) begin
                        st_nxt.dec.target = {I_INSTR[11:0], st_r.lo};
                        st_nxt.dec.fast = st_r.fast && st_r.pend == decoder_pkg::OP_CALL;
                        st_nxt.squash = 2'h1;
                    end
                end
            end else begin
                st_nxt.dec = decode(I_INSTR, st_r.bank, st_r.pre_asg);
                if (two_word(I_INSTR)) begin
                    // Output waits for the operand word, so the core sees one complete instruction.
                    st_nxt.dec.valid = 1'b0;
                    st_nxt.phase = decoder_pkg::PH_SECOND;
                    st_nxt.pend = st_nxt.dec.op;
                    st_nxt.hold12 = I_INSTR[11:0];
                    st_nxt.lo = I_INSTR[7:0];
                    st_nxt.fast = I_INSTR[8];
                end else if (st_nxt.dec.op == decoder_pkg::OP_RELBR) begin
                    st_nxt.squash = 2'h1;
                end
            end
        end
        if (st_r.dec.valid && st_r.dec.op == decoder_pkg::OP_MUL) begin
            st_nxt.prod = 16'(I_DP.acc) * 16'(I_DP.file_data);
        end
        // Read data is latched in the setup cycle so that it comes from a flip-flop.
        if (I_APB.psel && !I_APB.penable) begin
            st_nxt.slverr = 1'b0;
            case (I_APB.paddr)
                decoder_pkg::CTRL_OFS: st_nxt.prdata = {31'h0, st_r.pre_asg};
                decoder_pkg::BANK_OFS: st_nxt.prdata = {28'h0, st_r.bank};
                decoder_pkg::PROD_LO_OFS: st_nxt.prdata = {24'h0, st_r.prod[7:0]};
                decoder_pkg::PROD_HI_OFS: st_nxt.prdata = {24'h0, st_r.prod[15:8]};
                decoder_pkg::STAT_OFS: st_nxt.prdata = {22'h0, st_r.skip_arm, st_r.squash, st_r.phase, st_r.dec.op};
                default: begin
                    st_nxt.prdata = 32'h0;
                    st_nxt.slverr = 1'b1;
                end
            endcase
        end
        if (I_APB.psel && I_APB.penable && I_APB.pwrite) begin
            case (I_APB.paddr)
                decoder_pkg::CTRL_OFS: st_nxt.pre_asg = I_APB.pwdata[0];
                decoder_pkg::BANK_OFS: st_nxt.bank = I_APB.pwdata[3:0];
                default: st_nxt.pre_asg = st_r.pre_asg;
            endcase
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_DEC = st_r.dec;
    assign O_SKIP = st_r.skip;
    assign O_SKIP_CYC = st_r.skip_cyc;
    assign O_PROD_HI = st_r.prod[15:8];
    assign O_PROD_LO = st_r.prod[7:0];
    assign O_APB = {st_r.prdata, 1'b1, st_r.slverr};

    ////////////////////////////////////////////////////////////////////////////
    chk_dest_bank_addr: assert property (@(posedge I_MCLK) disable iff (I_RST)
        fresh && I_INSTR[15:10] == 6'h09 |=> O_DEC.valid && O_DEC.op == decoder_pkg::OP_ADD &&
        O_DEC.dest_file == $past(I_INSTR[9]) && O_DEC.addr[7:0] == $past(I_INSTR[7:0]) &&
        O_DEC.addr[11:8] == ($past(I_INSTR[8]) ? $past(st_r.bank) : decoder_pkg::ACCESS_BANK))
        else $error("byte op destination or address wrong");

    chk_move_second_word: assert property (@(posedge I_MCLK) disable iff (I_RST)
        fresh && I_INSTR[15:12] == 4'hc ##1 (I_INSTR_VLD && I_INSTR[15:12] == 4'hf) |=>
        O_DEC.op == decoder_pkg::OP_FMOVE && O_DEC.addr == $past(I_INSTR[11:0], 2) && O_DEC.fdst == $past(I_INSTR[11:0]))
        else $error("two-word move addresses wrong");

    chk_jump_target: assert property (@(posedge I_MCLK) disable iff (I_RST)
        fresh && I_INSTR[15:8] == 8'hef ##1 (I_INSTR_VLD && I_INSTR[15:12] == 4'hf) |=>
        O_DEC.target == {$past(I_INSTR[11:0]), $past(I_INSTR[7:0], 2)} && O_DEC.cycles == 2'h2)
        else $error("jump target wrong");

    chk_orphan_nop: assert property (@(posedge I_MCLK) disable iff (I_RST)
        fresh && I_INSTR[15:12] == 4'hf |=> O_DEC.valid && O_DEC.op == decoder_pkg::OP_NOP && !O_DEC.dest_file)
        else $error("orphan second word not a no-operation");

    chk_logic_flags: assert property (@(posedge I_MCLK) disable iff (I_RST)
        fresh && I_INSTR[15:12] == 4'h1 |=> O_DEC.flags == 5'h05 && O_DEC.cycles == 2'h1)
        else $error("logical op flags wrong");

    chk_skip_zero: assert property (@(posedge I_MCLK) disable iff (I_RST)
        O_DEC.valid && O_DEC.op == decoder_pkg::OP_DECSZ && I_DP.res_zero && I_INSTR_VLD |=>
        O_SKIP && O_SKIP_CYC == (two_word($past(I_INSTR)) ? 2'h3 : 2'h2) && O_DEC.op == decoder_pkg::OP_NOP)
        else $error("skip on zero not taken");

    chk_skip_nonzero: assert property (@(posedge I_MCLK) disable iff (I_RST)
        O_DEC.valid && O_DEC.op == decoder_pkg::OP_INCSNZ && !I_DP.res_zero && I_INSTR_VLD |=> O_SKIP)
        else $error("skip on nonzero not taken");

    chk_mul_product: assert property (@(posedge I_MCLK) disable iff (I_RST)
        O_DEC.valid && O_DEC.op == decoder_pkg::OP_MUL |-> O_DEC.flags == 5'h00 ##1
        {O_PROD_HI, O_PROD_LO} == 16'($past(I_DP.acc)) * 16'($past(I_DP.file_data)))
        else $error("product registers wrong");

    chk_branch_flush: assert property (@(posedge I_MCLK) disable iff (I_RST)
        fresh && I_INSTR[15:11] == 5'h1a ##1 I_INSTR_VLD |=> O_DEC.op == decoder_pkg::OP_NOP &&
        $past(O_DEC.offset) == $past(I_INSTR[10:0], 2))
        else $error("relative branch not flushed");

endmodule : byte_bit_instruction_decoder

/* tb/dp_model.sv */
// Datapath stand-in that answers the decoded instruction in the same cycle.
`timescale 1ns/1ps
module dp_model (
    // Decoded instruction and the condition chosen by the bench.
    input wire decoder_pkg::dec_s i_dec,
    input wire logic i_cond,
    // Datapath answer.
    output decoder_pkg::dp_s o_dp
);
    // The accumulator is fixed so that the product can be predicted from the file address alone.
    always_comb begin
        o_dp.acc = 8'h3c;
        o_dp.file_data = i_dec.addr[7:0];
        o_dp.res_zero = i_cond;
        o_dp.cmp_lt = i_cond;
        o_dp.cmp_eq = i_cond;
        o_dp.cmp_gt = i_cond;
    end
endmodule : dp_model

/* tb/tb_byte_bit_instruction_decoder.sv */
// Self-checking bench for the instruction decoder.
`timescale 1ns/1ps
module tb_byte_bit_instruction_decoder;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] instr = 16'h0000;
    logic vld = 1'b0;
    logic cond = 1'b0;
    decoder_pkg::apb_req_s apb = '0;
    decoder_pkg::apb_rsp_s rsp;
    decoder_pkg::dec_s dec;
    decoder_pkg::dp_s dp;
    logic skip;
    logic [1:0] skip_cyc;
    logic [7:0] ph;
    logic [7:0] pl;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    // Table rows follow the op enum order, so row i decodes as op i+1.
    logic [7:0] hi [30] = '{8'h20, 8'h24, 8'h28, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h60, 8'h62, 8'h64, 8'h2c,
        8'h3c, 8'h66, 8'h48, 8'h4c, 8'h34, 8'h30, 8'h44, 8'h40, 8'h5c, 8'h58, 8'h54, 8'h02, 8'h50, 8'h6a, 8'h68,
        8'h6c, 8'h6e, 8'h38};
    logic [4:0] fl [30] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h05, 5'h05, 5'h05, 5'h05, 5'h00, 5'h00, 5'h00, 5'h00,
        5'h00, 5'h00, 5'h00, 5'h00, 5'h15, 5'h15, 5'h05, 5'h05, 5'h1f, 5'h1f, 5'h1f, 5'h00, 5'h05, 5'h04, 5'h00,
        5'h1f, 5'h00, 5'h00};

    byte_bit_instruction_decoder u_byte_bit_instruction_decoder (.I_MCLK(clk), .I_RST(rst), .I_INSTR(instr),
        .I_INSTR_VLD(vld), .I_DP(dp), .I_APB(apb), .O_APB(rsp), .O_DEC(dec), .O_SKIP(skip), .O_SKIP_CYC(skip_cyc),
        .O_PROD_HI(ph), .O_PROD_LO(pl));
    dp_model u_dp_model (.i_dec(dec), .i_cond(cond), .o_dp(dp));

    initial forever #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            final_report();
        end
    end

    task eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : eq

    task op_eq(input decoder_pkg::op_e exp);
        eq(dec.valid, 1'b1, "valid");
        eq(dec.op, exp, "op");
    endtask : op_eq

    // The word handed in now is taken at the next edge, so dec shows the word of the call before.
    task step(input logic [15:0] w, input logic v);
        @(posedge clk);
        instr <= w;
        vld <= v;
        #1;
    endtask : step

    task apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        @(posedge clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'b1;
        // Ends at the first edge that sees pready high; the bench timeout catches a stall.
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask : apb_xfer

    ////////////////////////////////////////////////////////////////////////////////
    task t_apb;
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, decoder_pkg::BANK_OFS, 32'h5, rd, err);
        apb_xfer(1'b0, decoder_pkg::BANK_OFS, 32'h0, rd, err);
        eq(rd, 32'h5, "bank readback");
        apb_xfer(1'b1, decoder_pkg::PROD_LO_OFS, 32'hff, rd, err);
        eq(err, 1'b0, "read-only write error");
        apb_xfer(1'b0, decoder_pkg::PROD_LO_OFS, 32'h0, rd, err);
        eq(rd, 32'h0, "product low after write");
        apb_xfer(1'b0, 12'h020, 32'h0, rd, err);
        eq(err, 1'b1, "unmapped error");
        eq(rd, 32'h0, "unmapped data");
        $display("test apb done");
    endtask : t_apb

    task t_table;
        for (int i = 0; i < 30; i++) begin
            step({hi[i] | 8'(i % 2), 8'(i * 3)}, 1'b1);
            step(16'h0000, 1'b1);
            op_eq(decoder_pkg::op_e'(i + 1));
            eq(dec.flags, fl[i], "flags");
            eq(dec.addr, {(i % 2) ? 4'h5 : 4'h0, 8'(i * 3)}, "file address");
        end
        $display("test opcode table done");
    endtask : t_table

    task t_ports;
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, decoder_pkg::BANK_OFS, 32'hf, rd, err);
        apb_xfer(1'b1, decoder_pkg::CTRL_OFS, 32'h1, rd, err);
        step(16'h2b10, 1'b1);
        step(16'h2b00, 1'b1);
        eq(dec.addr, 32'hf10, "banked timer address");
        eq(dec.pre_clr, 1'b1, "prescaler clear");
        eq(dec.dest_file, 1'b1, "destination file");
        step(16'h2910, 1'b1);
        eq(dec.pin_src, 1'b1, "port operand from pins");
        eq(dec.pre_clr, 1'b0, "no prescaler clear off timer");
        step(16'h0000, 1'b1);
        eq(dec.dest_file, 1'b0, "destination accumulator");
        eq(dec.pre_clr, 1'b0, "no prescaler clear to accumulator");
        $display("test ports done");
    endtask : t_ports

    task t_formats;
        step(16'hc123, 1'b1);
        step(16'hf456, 1'b1);
        step(16'h9a55, 1'b1);
        op_eq(decoder_pkg::OP_FMOVE);
        eq({dec.addr, dec.fdst}, 32'h123456, "move addresses");
        step(16'h0e7f, 1'b1);
        op_eq(decoder_pkg::OP_BITOP);
        eq({dec.bit_sel, dec.addr}, {3'h5, 12'h055}, "bit and address");
        step(16'hf000, 1'b1);
        op_eq(decoder_pkg::OP_LIT);
        eq(dec.literal, 32'h7f, "literal");
        step(16'he2f0, 1'b1);
        op_eq(decoder_pkg::OP_NOP);
        step(16'h0000, 1'b0);
        op_eq(decoder_pkg::OP_BCOND);
        eq(dec.offset[7:0], 32'hf0, "branch offset");
        $display("test formats done");
    endtask : t_formats

    task t_branch;
        step(16'hd005, 1'b1);
        step(16'h2410, 1'b1);
        op_eq(decoder_pkg::OP_RELBR);
        eq({dec.offset, dec.cycles}, {11'h005, 2'h2}, "relative branch");
        step(16'hef34, 1'b1);
        op_eq(decoder_pkg::OP_NOP);
        step(16'hf123, 1'b1);
        eq(dec.valid, 1'b0, "first word silent");
        step(16'h0000, 1'b1);
        op_eq(decoder_pkg::OP_JUMP);
        eq({dec.target, dec.cycles}, {20'h12334, 2'h2}, "jump target");
        step(16'hed12, 1'b1);
        op_eq(decoder_pkg::OP_NOP);
        step(16'hf0ab, 1'b1);
        step(16'h0000, 1'b1);
        op_eq(decoder_pkg::OP_CALL);
        eq({dec.target, dec.fast}, {20'h0ab12, 1'b1}, "call target");
        step(16'h0000, 1'b0);
        op_eq(decoder_pkg::OP_NOP);
        $display("test branch done");
    endtask : t_branch

    task t_skip;
        cond <= 1'b1;
        step(16'h2e10, 1'b1);
        step(16'h2410, 1'b1);
        step(16'h0000, 1'b0);
        op_eq(decoder_pkg::OP_NOP);
        eq({skip, skip_cyc}, {1'b1, 2'h2}, "skip single word");
        step(16'h2e10, 1'b1);
        step(16'hc123, 1'b1);
        step(16'hf456, 1'b1);
        eq({skip, skip_cyc}, {1'b1, 2'h3}, "skip two-word");
        step(16'h0000, 1'b0);
        op_eq(decoder_pkg::OP_NOP);
        cond <= 1'b0;
        $display("test skip done");
    endtask : t_skip

    task t_mul;
        logic [31:0] rd;
        logic err;
        step(16'h0210, 1'b1);
        step(16'h0000, 1'b0);
        op_eq(decoder_pkg::OP_MUL);
        step(16'h0000, 1'b0);
        eq({ph, pl}, 32'h03c0, "product bytes");
        apb_xfer(1'b0, decoder_pkg::PROD_HI_OFS, 32'h0, rd, err);
        eq(rd, 32'h03, "product high readback");
        apb_xfer(1'b0, decoder_pkg::PROD_LO_OFS, 32'h0, rd, err);
        eq(rd, 32'hc0, "product low readback");
        $display("test multiply done");
    endtask : t_mul

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_apb();
        t_table();
        t_ports();
        t_formats();
        t_branch();
        t_skip();
        t_mul();
        final_report();
    end
endmodule : tb_byte_bit_instruction_decoder
